// file: gc_plane_datapath.v
`timescale 1ns/100ps
`include "gc_datapath_defs.vh"

module gc_plane_datapath (
	input  wire         clk,
	input  wire         rst,
	// Host I/O cycles
	input  wire         ioWr,
	input  wire         ioRd,
	input  wire [15:0]  ioAddr,
	input  wire [7:0]   ioWrData,
	output reg  [7:0]   ioRdData,
	output reg          ioRdValid,
	// Host memory cycles
	input  wire         memWr,
	input  wire         memRd,
	input  wire [3:0]   memByteEn,
	input  wire [1:0]   memAddrLow,
	input  wire [31:0]  memWrData,
	output reg  [31:0]  memRdData,
	output reg          memRdValid,
	// Sequencer addressing mode
	input  wire         quadMode,
	// Display planes, lane l plane p at [l*32+p*8 +: 8]
	input  wire [127:0] planeRdData,
	output reg  [127:0] planeWrData,
	output reg  [3:0]   planeWrLaneEn,
	output reg          planeWrStrobe
);

	// Controller registers
	reg [3:0]  indexReg;
	reg [7:0]  crtcIndexReg;
	reg [3:0]  fillValueReg;
	reg [3:0]  fillEnableReg;
	reg [3:0]  compareColourReg;
	reg [4:0]  rotateOpReg;
	reg [1:0]  readPlaneReg;
	reg [7:0]  modeReg;
	reg [3:0]  mapMiscReg;
	reg [3:0]  compareIgnoreReg;
	reg [7:0]  pixelMaskReg;
	reg [31:0] latchReg;

	// Next values for the read paths
	reg [7:0]  ioRdNext;
	reg [7:0]  gcRegValue;
	reg [31:0] memRdNext;
	reg [31:0] latchNext;
	reg [1:0]  lanePlane;
	reg [1:0]  laneAddr;
	reg [31:0] laneWord;
	reg [7:0]  compareByte;
	integer    l;

	// Decoded fields
	wire [1:0] writeMode = modeReg[`WMODE_MSB:`WMODE_LSB];
	wire       readMode = modeReg[`RMODE_BIT];
	wire       oddEven = modeReg[`ODD_EVEN_BIT] |
		mapMiscReg[`CHAIN_OE_BIT];
	wire [2:0] rotCount = rotateOpReg[`ROT_COUNT_MSB:`ROT_COUNT_LSB];
	wire [1:0] logicOp = rotateOpReg[`LOGIC_OP_MSB:`LOGIC_OP_LSB];
	wire [127:0] planeWrComb;

	// Port decode
	wire gcIndexHit = (ioAddr == `IO_GC_INDEX);
	wire gcDataHit = (ioAddr == `IO_GC_DATA);
	wire crtcIndexHit = (ioAddr == `IO_CRTC_INDEX_MONO) ||
		(ioAddr == `IO_CRTC_INDEX_COL);
	wire crtcDataHit = (ioAddr == `IO_CRTC_DATA_MONO) ||
		(ioAddr == `IO_CRTC_DATA_COL);

	// Pixel-wise colour compare over four plane bytes
	function [7:0] colourMatch;
		input [31:0] w;
		input [3:0]  colour;
		input [3:0]  care;
		integer      i;
		reg   [3:0]  pix;
		begin
			colourMatch = 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				pix = {w[24+i], w[16+i], w[8+i], w[i]};
				// Only enabled planes take part
				colourMatch[i] = ~|((pix ^ colour) & care);
			end
		end
	endfunction

	// Plane served to a lane in plane-select mode
	function [1:0] pickPlane;
		input [1:0] sel;
		input [1:0] addr;
		input       oe;
		input       quad;
		begin
			if (quad) begin
				pickPlane = addr;
			end else if (oe) begin
				pickPlane = {sel[1], addr[0]};
			end else begin
				pickPlane = sel;
			end
		end
	endfunction

	// Masked register image for a given index
	function [7:0] regImage;
		input [3:0] idx;
		input [3:0] fv;
		input [3:0] fe;
		input [3:0] cc;
		input [4:0] ro;
		input [1:0] rp;
		input [7:0] md;
		input [3:0] mm;
		input [3:0] ci;
		input [7:0] pm;
		begin
			case (idx)
			`IDX_PLANE_FILL_VALUE:     regImage = {4'h0, fv};
			`IDX_PLANE_FILL_ENABLE:    regImage = {4'h0, fe};
			`IDX_COMPARE_COLOUR:       regImage = {4'h0, cc};
			`IDX_ROTATE_AND_LOGIC_OP:  regImage = {3'h0, ro};
			`IDX_READ_PLANE_CHOICE:    regImage = {6'h00, rp};
			`IDX_DATAPATH_MODE:        regImage = md & `MASK_MODE;
			`IDX_MEMORY_MAP_MISC:      regImage = {4'h0, mm};
			`IDX_COMPARE_PLANE_IGNORE: regImage = {4'h0, ci};
			`IDX_PIXEL_WRITE_MASK:     regImage = pm;
			default:                   regImage = 8'h00;
			endcase
		end
	endfunction

	// One writer per byte lane
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : laneWriter
			plane_byte_writer writer (
				.cpuByte   (memWrData[g*8 +: 8]),
				.latchWord (latchReg),
				.fillValue (fillValueReg),
				.fillEnable(fillEnableReg),
				.rotCount  (rotCount),
				.logicOp   (logicOp),
				.writeMode (writeMode),
				.bitMask   (pixelMaskReg),
				.planeWord (planeWrComb[g*32 +: 32])
			);
		end
	endgenerate

	// Register writes through index and data ports
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			indexReg <= 4'h0;
			crtcIndexReg <= `REG_RESET;
			fillValueReg <= 4'h0;
			fillEnableReg <= 4'h0;
			compareColourReg <= 4'h0;
			rotateOpReg <= 5'h00;
			readPlaneReg <= 2'h0;
			modeReg <= `REG_RESET;
			mapMiscReg <= 4'h0;
			compareIgnoreReg <= 4'h0;
			pixelMaskReg <= `REG_RESET;
		end else if (ioWr) begin
			if (gcIndexHit) begin
				indexReg <= ioWrData[3:0];
			end
			if (crtcIndexHit) begin
				crtcIndexReg <= ioWrData;
			end
			// Latch readback index has no write path
			if (gcDataHit) begin
				case (indexReg)
				`IDX_PLANE_FILL_VALUE:     fillValueReg <= ioWrData[3:0];
				`IDX_PLANE_FILL_ENABLE:    fillEnableReg <= ioWrData[3:0];
				`IDX_COMPARE_COLOUR:       compareColourReg <= ioWrData[3:0];
				`IDX_ROTATE_AND_LOGIC_OP:  rotateOpReg <= ioWrData[4:0];
				`IDX_READ_PLANE_CHOICE:    readPlaneReg <= ioWrData[1:0];
				`IDX_DATAPATH_MODE:        modeReg <= ioWrData & `MASK_MODE;
				`IDX_MEMORY_MAP_MISC:      mapMiscReg <= ioWrData[3:0];
				`IDX_COMPARE_PLANE_IGNORE: compareIgnoreReg <= ioWrData[3:0];
				`IDX_PIXEL_WRITE_MASK:     pixelMaskReg <= ioWrData;
				default:                   ;
				endcase
			end
		end
	end

	// I/O read mux; unmapped ports read zero
	always @* begin
		gcRegValue = regImage(indexReg, fillValueReg, fillEnableReg,
			compareColourReg, rotateOpReg, readPlaneReg, modeReg,
			mapMiscReg, compareIgnoreReg, pixelMaskReg);
		ioRdNext = 8'h00;
		if (gcIndexHit) begin
			ioRdNext = {4'h0, indexReg};
		end else if (gcDataHit) begin
			ioRdNext = gcRegValue;
		end else if (crtcIndexHit) begin
			ioRdNext = crtcIndexReg;
		end else if (crtcDataHit &&
			crtcIndexReg == `IDX_LATCH_READBACK) begin
			ioRdNext = latchReg[readPlaneReg*8 +: 8];
		end
	end

	// Registered I/O answer one cycle after the request
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ioRdData <= 8'h00;
			ioRdValid <= 1'b0;
		end else begin
			ioRdValid <= ioRd;
			if (ioRd) begin
				ioRdData <= ioRdNext;
			end
		end
	end

	// Memory read reduction, lane by lane
	always @* begin
		memRdNext = 32'h0000_0000;
		latchNext = latchReg;
		lanePlane = 2'h0;
		laneAddr = 2'h0;
		laneWord = 32'h0000_0000;
		compareByte = 8'h00;
		for (l = 0; l < 4; l = l + 1) begin
			laneWord = planeRdData[l*32 +: 32];
			laneAddr = memAddrLow + l[1:0];
			lanePlane = pickPlane(readPlaneReg, laneAddr, oddEven, quadMode);
			compareByte = colourMatch(laneWord, compareColourReg,
				compareIgnoreReg);
			if (memByteEn[l]) begin
				// Wide reads repeat the reduction on every enabled byte
				if (readMode) begin
					memRdNext[l*8 +: 8] = compareByte;
				end else begin
					memRdNext[l*8 +: 8] = laneWord[lanePlane*8 +: 8];
				end
				// Highest enabled lane is the last byte read
				latchNext = laneWord;
			end
		end
	end

	// Latches reload on each memory read, data answered next cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			latchReg <= 32'h0000_0000;
			memRdData <= 32'h0000_0000;
			memRdValid <= 1'b0;
		end else begin
			memRdValid <= memRd;
			if (memRd) begin
				latchReg <= latchNext;
				memRdData <= memRdNext;
			end
		end
	end

	// Plane write issue; a read in the same cycle takes precedence
	// over the write for the latch, writes use the old latch value
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			planeWrData <= 128'h0;
			planeWrLaneEn <= 4'h0;
			planeWrStrobe <= 1'b0;
		end else begin
			planeWrStrobe <= memWr;
			if (memWr) begin
				planeWrData <= planeWrComb;
				planeWrLaneEn <= memByteEn;
			end else begin
				planeWrLaneEn <= 4'h0;
			end
		end
	end

endmodule

// file: gc_datapath_defs.vh
`ifndef GC_DATAPATH_DEFS_VH
`define GC_DATAPATH_DEFS_VH

// Host I/O port addresses
`define IO_GC_INDEX        16'h03CE
`define IO_GC_DATA         16'h03CF
`define IO_CRTC_INDEX_MONO 16'h03B4
`define IO_CRTC_DATA_MONO  16'h03B5
`define IO_CRTC_INDEX_COL  16'h03D4
`define IO_CRTC_DATA_COL   16'h03D5

// Controller register indices
`define IDX_PLANE_FILL_VALUE     4'h0
`define IDX_PLANE_FILL_ENABLE    4'h1
`define IDX_COMPARE_COLOUR       4'h2
`define IDX_ROTATE_AND_LOGIC_OP  4'h3
`define IDX_READ_PLANE_CHOICE    4'h4
`define IDX_DATAPATH_MODE        4'h5
`define IDX_MEMORY_MAP_MISC      4'h6
`define IDX_COMPARE_PLANE_IGNORE 4'h7
`define IDX_PIXEL_WRITE_MASK     4'h8
`define IDX_LATCH_READBACK       8'h22

// Writable bit masks, reserved bits read as zero
`define MASK_INDEX        8'h0F
`define MASK_NIBBLE       8'h0F
`define MASK_ROTATE_OP    8'h1F
`define MASK_READ_PLANE   8'h03
`define MASK_MODE         8'h7B
`define MASK_FULL         8'hFF

// Field positions
`define ROT_COUNT_MSB     2
`define ROT_COUNT_LSB     0
`define LOGIC_OP_MSB      4
`define LOGIC_OP_LSB      3
`define WMODE_MSB         1
`define WMODE_LSB         0
`define RMODE_BIT         3
`define ODD_EVEN_BIT      4
`define CHAIN_OE_BIT      1

// Write modes and logic functions
`define WMODE_0           2'h0
`define WMODE_1           2'h1
`define WMODE_2           2'h2
`define WMODE_3           2'h3
`define LOP_PASS          2'h0
`define LOP_AND           2'h1
`define LOP_OR            2'h2
`define LOP_XOR           2'h3

// Reset value of every controller register
`define REG_RESET         8'h00

`endif

// file: plane_byte_writer.v
`timescale 1ns/100ps
`include "gc_datapath_defs.vh"

module plane_byte_writer (
	input  wire [7:0]  cpuByte,
	input  wire [31:0] latchWord,
	input  wire [3:0]  fillValue,
	input  wire [3:0]  fillEnable,
	input  wire [2:0]  rotCount,
	input  wire [1:0]  logicOp,
	input  wire [1:0]  writeMode,
	input  wire [7:0]  bitMask,
	output reg  [31:0] planeWord
);

	// Right rotate of one byte by 0..7
	function [7:0] rotr8;
		input [7:0] d;
		input [2:0] n;
		reg   [15:0] t;
		begin
			t = {d, d} >> n;
			rotr8 = t[7:0];
		end
	endfunction

	// Combine data with latch byte
	function [7:0] alu8;
		input [7:0] d;
		input [7:0] l;
		input [1:0] op;
		begin
			case (op)
			`LOP_AND: alu8 = d & l;
			`LOP_OR:  alu8 = d | l;
			`LOP_XOR: alu8 = d ^ l;
			default:  alu8 = d;
			endcase
		end
	endfunction

	reg [7:0] rotated;
	reg [7:0] pixMask;
	reg [7:0] srcByte;
	reg [7:0] opByte;
	reg [7:0] latByte;
	integer   p;

	// One byte lane; each lane of a wide write has its own instance
	always @* begin
		rotated = 8'h00;
		pixMask = 8'h00;
		srcByte = 8'h00;
		opByte = 8'h00;
		latByte = 8'h00;
		planeWord = 32'h0000_0000;
		// Rotation only in modes 0 and 3
		if (writeMode == `WMODE_0 || writeMode == `WMODE_3) begin
			rotated = rotr8(cpuByte, rotCount);
		end else begin
			rotated = cpuByte;
		end
		// Mode 3 narrows the mask by the rotated data
		if (writeMode == `WMODE_3) begin
			pixMask = rotated & bitMask;
		end else begin
			pixMask = bitMask;
		end
		for (p = 0; p < 4; p = p + 1) begin
			latByte = latchWord[p*8 +: 8];
			case (writeMode)
			`WMODE_0: begin
				// Fill enable acts only here
				if (fillEnable[p]) begin
					srcByte = {8{fillValue[p]}};
				end else begin
					srcByte = rotated;
				end
			end
			`WMODE_2: srcByte = {8{cpuByte[p]}};
			`WMODE_3: srcByte = {8{fillValue[p]}};
			default:  srcByte = latByte;
			endcase
			if (writeMode == `WMODE_1) begin
				opByte = latByte;
			end else begin
				opByte = alu8(srcByte, latByte, logicOp);
			end
			// Masked pixels keep the latch value
			planeWord[p*8 +: 8] = (opByte & pixMask) |
				(latByte & ~pixMask);
		end
	end

endmodule

// file: gc_plane_datapath_asserts.sv
`timescale 1ns/100ps
`include "gc_datapath_defs.vh"
module gc_plane_datapath_asserts (
	input wire         clk,
	input wire         rst,
	input wire         ioRd,
	input wire [15:0]  ioAddr,
	input wire [7:0]   ioRdData,
	input wire         ioRdValid,
	input wire         memWr,
	input wire         memRd,
	input wire [3:0]   memByteEn,
	input wire [31:0]  memRdData,
	input wire         memRdValid,
	input wire [127:0] planeWrData,
	input wire [3:0]   planeWrLaneEn,
	input wire         planeWrStrobe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Answers land exactly one cycle after the request
	io_answer_a: assert property (ioRdValid == $past(ioRd))
		else $error("io read valid out of step");
	index_zero_a: assert property (ioRd && ioAddr == `IO_GC_INDEX
		|=> ioRdData[7:4] == 4'h0) else $error("index upper bits set");
	io_hold_a: assert property (!ioRd |=> $stable(ioRdData))
		else $error("io read data moved");
	mem_answer_a: assert property (memRdValid == $past(memRd))
		else $error("memory read valid out of step");
	mem_hold_a: assert property (!memRd |=> $stable(memRdData))
		else $error("memory read data moved");
	lane_off_a: assert property (memRd && !memByteEn[0]
		|=> memRdData[7:0] == 8'h00) else $error("disabled lane not zero");
	// Lanes written follow the byte enables of the request
	write_lanes_a: assert property (memWr |=> planeWrStrobe
		&& planeWrLaneEn == $past(memByteEn)) else $error("write lanes");
	no_write_a: assert property (!memWr |=> !planeWrStrobe
		&& planeWrLaneEn == 4'h0) else $error("write without request");
	wr_hold_a: assert property (!memWr |=> $stable(planeWrData))
		else $error("plane write data moved");
endmodule
bind gc_plane_datapath gc_plane_datapath_asserts u_chk (.clk(clk),
	.rst(rst), .ioRd(ioRd), .ioAddr(ioAddr), .ioRdData(ioRdData),
	.ioRdValid(ioRdValid), .memWr(memWr), .memRd(memRd),
	.memByteEn(memByteEn), .memRdData(memRdData),
	.memRdValid(memRdValid), .planeWrData(planeWrData),
	.planeWrLaneEn(planeWrLaneEn), .planeWrStrobe(planeWrStrobe));

// file: plane_memory_model.sv
`timescale 1ns/100ps
module plane_memory_model (
	input  wire         clk,
	input  wire         loadEn,
	input  wire [127:0] loadData,
	input  wire [127:0] planeWrData,
	input  wire [3:0]   planeWrLaneEn,
	input  wire         planeWrStrobe,
	output reg  [127:0] planeRdData
);
	integer l;
	// One addressed word; bench preload wins over a plane write
	always @(posedge clk) begin
		if (loadEn)
			planeRdData <= loadData;
		else if (planeWrStrobe)
			for (l = 0; l < 4; l = l + 1)
				if (planeWrLaneEn[l])
					planeRdData[l*32 +: 32] <= planeWrData[l*32 +: 32];
	end
endmodule

// file: gc_plane_datapath_test.sv
`timescale 1ns/100ps
`include "gc_datapath_defs.vh"
module gc_plane_datapath_test;
	reg          clk, rst, ioWr, ioRd, memWr, memRd, quadMode, loadEn;
	reg  [15:0]  ioAddr;
	reg  [7:0]   ioWrData, rv, rg [0:8];
	reg  [3:0]   memByteEn, be;
	reg  [1:0]   memAddrLow;
	reg  [31:0]  memWrData, lat;
	reg  [127:0] loadData, pd, ex, lm;
	wire [7:0]   ioRdData;
	wire         ioRdValid, memRdValid, planeWrStrobe;
	wire [31:0]  memRdData;
	wire [127:0] planeRdData, planeWrData;
	wire [3:0]   planeWrLaneEn;
	integer      seed, miscompares, compares, i, n, l;
	gc_plane_datapath u_dut (.clk(clk), .rst(rst), .ioWr(ioWr),
		.ioRd(ioRd), .ioAddr(ioAddr), .ioWrData(ioWrData),
		.ioRdData(ioRdData), .ioRdValid(ioRdValid), .memWr(memWr),
		.memRd(memRd), .memByteEn(memByteEn), .memAddrLow(memAddrLow),
		.memWrData(memWrData), .memRdData(memRdData),
		.memRdValid(memRdValid), .quadMode(quadMode),
		.planeRdData(planeRdData), .planeWrData(planeWrData),
		.planeWrLaneEn(planeWrLaneEn), .planeWrStrobe(planeWrStrobe));
	plane_memory_model u_mem (.clk(clk), .loadEn(loadEn),
		.loadData(loadData), .planeWrData(planeWrData),
		.planeWrLaneEn(planeWrLaneEn), .planeWrStrobe(planeWrStrobe),
		.planeRdData(planeRdData));
	always #5 clk = ~clk;
	// Writable bits per register index
	function [7:0] msk(input integer x);
		msk = x == 3 ? 8'h1F : x == 4 ? 8'h03 : x == 5 ? 8'h7B :
			x == 8 ? 8'hFF : 8'h0F;
	endfunction
	// Logic function, then bit mask falls back to the latch
	function [7:0] mix(input [7:0] s, input [7:0] lt, input [7:0] m);
		reg [7:0] v;
		begin
			case (rg[3][4:3])
			2'h0: v = s;
			2'h1: v = s & lt;
			2'h2: v = s | lt;
			default: v = s ^ lt;
			endcase
			mix = (v & m) | (lt & ~m);
		end
	endfunction
	// Expected plane bytes of one written lane
	function [31:0] wlane(input [7:0] c, input [31:0] lt);
		reg [7:0] d, s, m;
		integer q;
		begin
			d = {c, c} >> rg[3][2:0];
			for (q = 0; q < 4; q = q + 1) begin
				s = {8{rg[0][q]}};
				m = rg[8];
				case (rg[5][1:0])
				2'h0: s = rg[1][q] ? s : d;
				2'h1: m = 8'h00;
				2'h2: s = {8{c[q]}};
				default: m = d & rg[8];
				endcase
				wlane[q*8 +: 8] = mix(s, lt[q*8 +: 8], m);
			end
		end
	endfunction
	// Expected reduced byte of one read lane
	function [7:0] rlane(input [31:0] w, input [1:0] a);
		reg [1:0] ps;
		integer b;
		begin
			ps = quadMode ? a : (rg[5][4] | rg[6][1]) ?
				{rg[4][1], a[0]} : rg[4][1:0];
			for (b = 0; b < 8; b = b + 1)
				rlane[b] = ~|(({w[24+b], w[16+b], w[8+b], w[b]}
					^ rg[2][3:0]) & rg[7][3:0]);
			if (!rg[5][3])
				rlane = w[ps*8 +: 8];
		end
	endfunction
	task chk(input string nm, input [127:0] e, input [127:0] g);
		begin
			compares = compares + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("mismatch %s expected %0h seen %0h", nm, e, g);
			end
		end
	endtask
	// One I/O cycle; read data taken with the valid pulse
	task io(input w, input [15:0] a, input [7:0] d);
		begin
			@(negedge clk);
			ioWr = w;
			ioRd = !w;
			ioAddr = a;
			ioWrData = d;
			@(negedge clk);
			ioWr = 0;
			ioRd = 0;
			rv = ioRdData;
			if (!w)
				chk("ioRdValid", 1, ioRdValid);
		end
	endtask
	task wr(input [3:0] x, input [7:0] v);
		begin
			io(1, `IO_GC_INDEX, {4'h0, x});
			io(1, `IO_GC_DATA, v);
			rg[x] = v;
		end
	endtask
	// Preload planes then read; latch follows highest enabled lane
	task mrd(input [3:0] en, input [1:0] a);
		begin
			@(negedge clk);
			loadEn = 1;
			loadData = pd;
			@(negedge clk);
			loadEn = 0;
			memRd = 1;
			memByteEn = en;
			memAddrLow = a;
			@(negedge clk);
			memRd = 0;
			for (l = 0; l < 4; l = l + 1) begin
				ex[l*8 +: 8] = en[l] ? rlane(pd[l*32 +: 32], a + l[1:0]) : 0;
				if (en[l])
					lat = pd[l*32 +: 32];
			end
			chk("memRdValid", 1, memRdValid);
			chk("memRdData", ex[31:0], memRdData);
		end
	endtask
	task mwr(input [3:0] en, input [31:0] d);
		begin
			@(negedge clk);
			memWr = 1;
			memByteEn = en;
			memWrData = d;
			@(negedge clk);
			memWr = 0;
			chk("planeWrStrobe", 1, planeWrStrobe);
			chk("planeWrLaneEn", en, planeWrLaneEn);
			// Lanes not written are masked out of the compare
			for (l = 0; l < 4; l = l + 1) begin
				ex[l*32 +: 32] = en[l] ? wlane(d[l*8 +: 8], lat) : 0;
				lm[l*32 +: 32] = {32{en[l]}};
			end
			chk("planeWrData", ex, planeWrData & lm);
		end
	endtask
	task complete_run;
		begin
			$display("compares %0d miscompares %0d", compares, miscompares);
			if (miscompares == 0 && compares > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// Run is near 13k cycles; a hang stops at 30k
	initial begin
		#300000;
		miscompares = miscompares + 1;
		complete_run;
	end
	initial begin
		{clk, ioWr, ioRd, memWr, memRd, quadMode, loadEn} = 0;
		{ioAddr, ioWrData, memByteEn, memAddrLow, memWrData} = 0;
		{loadData, pd, lat} = 0;
		seed = 1;
		miscompares = 0;
		compares = 0;
		rst = 1;
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst = 0;
		// Index ignores upper bits; registers clear, then keep masked bits
		for (i = 0; i < 9; i = i + 1) begin
			io(1, `IO_GC_INDEX, {4'hA, i[3:0]});
			io(0, `IO_GC_INDEX, 8'h00);
			chk("index", i, rv);
			io(0, `IO_GC_DATA, 8'h00);
			chk("reset value", 0, rv);
			wr(i[3:0], $random(seed));
			io(0, `IO_GC_DATA, 8'h00);
			chk("register", rg[i] & msk(i), rv);
		end
		$display("test registers done");
		// Every write mode in turn, random ops, rotations and masks
		for (n = 0; n < 200; n = n + 1) begin
			for (i = 0; i < 9; i = i + 1)
				wr(i[3:0], $random(seed));
			wr(4'h5, {6'h0, n[1:0]});
			wr(4'h6, 8'h00);
			pd = {$random(seed), $random(seed), $random(seed), $random(seed)};
			be = $random(seed);
			mrd(be | 4'h1, $random(seed));
			mwr($random(seed), $random(seed));
		end
		$display("test writes done");
		// Reads in every addressing and read mode, then latch readback
		for (n = 0; n < 64; n = n + 1) begin
			for (i = 0; i < 9; i = i + 1)
				wr(i[3:0], $random(seed));
			wr(4'h5, {3'h0, n[1], n[0], 3'h0});
			quadMode = n[2];
			pd = {$random(seed), $random(seed), $random(seed), $random(seed)};
			mrd($random(seed), $random(seed));
			// Mono and colour port pairs alike
			io(1, n[3] ? `IO_CRTC_INDEX_MONO : `IO_CRTC_INDEX_COL,
				`IDX_LATCH_READBACK);
			io(1, n[3] ? `IO_CRTC_DATA_MONO : `IO_CRTC_DATA_COL, ~lat[7:0]);
			io(0, n[3] ? `IO_CRTC_DATA_MONO : `IO_CRTC_DATA_COL, 8'h00);
			chk("latch readback", lat[rg[4][1:0]*8 +: 8], rv);
		end
		$display("test reads done");
		// Reset in mid-run clears the registers again
		@(negedge clk);
		rst = 1;
		@(negedge clk);
		rst = 0;
		io(1, `IO_GC_INDEX, 8'h08);
		io(0, `IO_GC_DATA, 8'h00);
		chk("mask after reset", 0, rv);
		io(1, `IO_CRTC_INDEX_MONO, `IDX_LATCH_READBACK);
		io(0, `IO_CRTC_DATA_MONO, 8'h00);
		chk("latch after reset", 0, rv);
		// Index past the last register and unmapped ports read zero
		io(1, `IO_GC_INDEX, 8'h09);
		io(0, `IO_GC_DATA, 8'h00);
		chk("index past end", 0, rv);
		io(0, 16'h03C0, 8'h00);
		chk("unmapped port", 0, rv);
		$display("test second reset done");
		complete_run;
	end
endmodule
